// ==== asr_pkg.sv ====
// asr_pkg: constants and types for the alarm status register set
// assumes: compiled before asr_alarm_status; no bus, registers reached by commands
package asr_pkg;

  // ----------------------------------------
  // bit layout of condition, event and enable registers
  // ----------------------------------------
  localparam int unsigned ASR_QNE_BIT    = 4;
  localparam int unsigned ASR_ALM1_BIT   = 6;
  localparam int unsigned ASR_LOWER_BIT  = 12;
  localparam int unsigned ASR_UPPER_BIT  = 13;
  localparam int unsigned ASR_NUM_ALARMS = 4;
  localparam logic [15:0] ASR_USED_MASK  = 16'h33D0;

  // ----------------------------------------
  // reset values and queue sizing
  // ----------------------------------------
  localparam logic [15:0] ASR_ENABLE_RST = 16'h0000;
  localparam logic [15:0] ASR_EVENT_RST  = 16'h0000;
  localparam int unsigned ASR_QCNT_W     = 8;
  localparam logic [7:0]  ASR_QCNT_MAX   = 8'hFF;
  localparam logic [7:0]  ASR_QCNT_RST   = 8'h00;

  // ----------------------------------------
  // query selector and state record
  // ----------------------------------------
  typedef enum logic [1:0] {
    ASR_SEL_COND,
    ASR_SEL_EVENT,
    ASR_SEL_ENABLE
  } asr_sel_t;

  typedef struct packed {
    logic [15:0]           enable;
    logic [15:0]           event_reg;
    logic [15:0]           prev_cond;
    logic [ASR_QCNT_W-1:0] qcount;
    logic [15:0]           rdata;
    logic                  rvalid;
    logic                  summary;
    logic [15:0]           cond_out;
  } asr_state_t;

endpackage

// ==== asr_alarm_status.sv ====
// asr_alarm_status: alarm condition, event and enable registers with summary
// assumes: commands arrive as one-cycle strobes on clk; alarm levels synchronous
//
// Functional notes
// (R1) condition register read-only, reads leave it intact
// (R2) clear-status empties queue, clears bit 4
// (R3) bit 4 set while queue holds entries
// (R4) alarms 1-4 on bits 6-9, unused zero
// (R5) lower limit bit 12, upper bit 13
// (R6) query returns binary-weighted integer of bits
// (R7) enable register writable, readable, 16 bits; code stores only the ASR_USED_MASK bits
// (R8) report upward only through enabled bits
// (R9) status-preset loads enable with zero
// (R10) event bits latch until query or clear
// (R11) summary is OR of event AND enable
`timescale 1ns/1ps
module asr_alarm_status
  import asr_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // alarm sources
  input  wire logic [ASR_NUM_ALARMS-1:0] alarm_level,
  input  wire logic                      lower_limit,
  input  wire logic                      upper_limit,
  input  wire logic                      queue_push,
  input  wire logic                      queue_pop,
  // commands
  input  wire logic                      clear_status,
  input  wire logic                      status_preset,
  input  wire logic                      enable_write,
  input  wire logic [15:0]               enable_wdata,
  input  wire logic                      query,
  input  wire asr_sel_t                  query_sel,
  // answers
  output logic [15:0]                    query_data,
  output logic                           query_valid,
  output logic                           alarm_summary,
  output logic [15:0]                    alarm_condition
);

  asr_state_t st;
  asr_state_t next_st;
  logic [15:0] cond;
  logic        q_ne;
  logic [ASR_QCNT_W-1:0] next_q;

  // ----------------------------------------
  // condition register assembly
  // ----------------------------------------
  always_comb begin
    cond = 16'h0000;
    q_ne = (st.qcount != ASR_QCNT_RST);
    cond[ASR_QNE_BIT] = q_ne; // [R3]
    cond[ASR_ALM1_BIT +: ASR_NUM_ALARMS] = alarm_level; // [R4]
    cond[ASR_LOWER_BIT] = lower_limit; // [R5]
    cond[ASR_UPPER_BIT] = upper_limit; // [R5]
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // queue occupancy; clear-status empties it
    next_q = st.qcount;
    if (queue_push && !queue_pop && st.qcount != ASR_QCNT_MAX) begin
      next_q = st.qcount + 8'h01;
    end else if (queue_pop && !queue_push && q_ne) begin
      next_q = st.qcount - 8'h01;
    end
    if (clear_status) begin
      next_q = ASR_QCNT_RST; // [R2]
    end
    next_st.qcount = next_q;
    // enable register, preset wins over write
    if (enable_write) begin
      next_st.enable = enable_wdata & ASR_USED_MASK; // [R7]
    end
    if (status_preset) begin
      next_st.enable = ASR_ENABLE_RST; // [R9]
    end
    // event latch: clear by query or clear-status, new rise wins
    if (clear_status || (query && query_sel == ASR_SEL_EVENT)) begin
      next_st.event_reg = ASR_EVENT_RST; // [R10]
    end
    next_st.event_reg = next_st.event_reg | (cond & ~st.prev_cond); // [R10]
    next_st.prev_cond = cond;
    // query answer; condition read has no side effect
    next_st.rvalid = query;
    if (query) begin
      case (query_sel)
        ASR_SEL_COND:   next_st.rdata = cond; // [R1] [R6]
        ASR_SEL_EVENT:  next_st.rdata = st.event_reg; // [R6]
        ASR_SEL_ENABLE: next_st.rdata = st.enable; // [R7]
        default:        next_st.rdata = 16'h0000;
      endcase
    end
    next_st.summary = |(st.event_reg & st.enable); // [R8] [R11]
    next_st.cond_out = cond;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign query_data      = st.rdata;
  assign query_valid     = st.rvalid;
  assign alarm_summary   = st.summary;
  assign alarm_condition = st.cond_out;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // helper terms shared by the checks below
  logic [15:0] chk_rise;
  logic        chk_evq;

  always_comb begin
    chk_rise = cond & ~st.prev_cond;
    chk_evq  = query && (query_sel == ASR_SEL_EVENT);
  end

  // ----------------------------------------
  // condition register
  // ----------------------------------------
  // unused positions always read zero
  a_unused_zero: assert property (@(posedge clk) disable iff (reset) // [R4]
    (alarm_condition & ~ASR_USED_MASK) == 16'h0000)
    else $error("unused condition bit set");

  // condition query answers the live value
  a_cond_read: assert property (@(posedge clk) disable iff (reset) // [R1]
    query && query_sel == ASR_SEL_COND |=> query_valid && query_data == $past(cond))
    else $error("condition query wrong");

  // registered copy trails the live value by one cycle
  a_cond_copy: assert property (@(posedge clk) disable iff (reset) // [R1]
    !reset |=> alarm_condition == $past(cond))
    else $error("condition copy wrong");

  // alarms one to four land on their own bits
  a_alarm_map: assert property (@(posedge clk) disable iff (reset) // [R4]
    !reset |=> alarm_condition[ASR_ALM1_BIT +: ASR_NUM_ALARMS] == $past(alarm_level))
    else $error("alarm bits misplaced");

  // limit alarms land on bits 12 and 13
  a_limit_map: assert property (@(posedge clk) disable iff (reset) // [R5]
    !reset |=> alarm_condition[ASR_LOWER_BIT] == $past(lower_limit)
    && alarm_condition[ASR_UPPER_BIT] == $past(upper_limit))
    else $error("limit bits misplaced");

  // queue flag follows the occupancy counter
  a_qne_map: assert property (@(posedge clk) disable iff (reset) // [R3]
    !reset |=> alarm_condition[ASR_QNE_BIT] == $past(st.qcount != ASR_QCNT_RST))
    else $error("queue flag mismatch");

  // ----------------------------------------
  // alarm queue
  // ----------------------------------------
  // clear-status drops the flag two cycles on
  a_qne_clear: assert property (@(posedge clk) disable iff (reset) // [R2]
    clear_status && !queue_push |=> ##1 !alarm_condition[ASR_QNE_BIT])
    else $error("queue flag not cleared");

  // a push raises the flag two cycles on
  a_qne_set: assert property (@(posedge clk) disable iff (reset) // [R3]
    queue_push && !queue_pop && !clear_status |=> ##1 alarm_condition[ASR_QNE_BIT])
    else $error("queue flag not set");

  // clear-status empties the counter at once
  a_qcnt_clear: assert property (@(posedge clk) disable iff (reset) // [R2]
    clear_status |=> st.qcount == ASR_QCNT_RST)
    else $error("queue not emptied");

  // lone push adds one below the ceiling
  a_qcnt_push: assert property (@(posedge clk) disable iff (reset) // [R3]
    queue_push && !queue_pop && !clear_status && st.qcount != ASR_QCNT_MAX
    |=> st.qcount == $past(st.qcount) + 8'h01)
    else $error("push not counted");

  // lone pop removes one when not empty
  a_qcnt_pop: assert property (@(posedge clk) disable iff (reset) // [R3]
    queue_pop && !queue_push && !clear_status && st.qcount != ASR_QCNT_RST
    |=> st.qcount == $past(st.qcount) - 8'h01)
    else $error("pop not counted");

  // full counter never wraps to empty
  a_qcnt_sat: assert property (@(posedge clk) disable iff (reset) // [R3]
    queue_push && !queue_pop && !clear_status && st.qcount == ASR_QCNT_MAX
    |=> st.qcount == ASR_QCNT_MAX)
    else $error("queue counter wrapped");

  // pop on empty leaves it empty
  a_qcnt_floor: assert property (@(posedge clk) disable iff (reset) // [R3]
    queue_pop && !queue_push && !clear_status && st.qcount == ASR_QCNT_RST
    |=> st.qcount == ASR_QCNT_RST)
    else $error("queue counter underflow");

  // no net movement holds the count
  a_qcnt_idle: assert property (@(posedge clk) disable iff (reset) // [R3]
    queue_push == queue_pop && !clear_status |=> st.qcount == $past(st.qcount))
    else $error("queue counter drifted");

  // ----------------------------------------
  // enable register
  // ----------------------------------------
  // status-preset zeroes the register
  a_preset_zero: assert property (@(posedge clk) disable iff (reset) // [R9]
    status_preset |=> st.enable == 16'h0000)
    else $error("preset left enable set");

  // written value reads back, masked
  a_enable_rw: assert property (@(posedge clk) disable iff (reset) // [R7]
    enable_write && !status_preset ##1 query && query_sel == ASR_SEL_ENABLE && !enable_write
    && !status_preset |=> query_data == ($past(enable_wdata, 2) & ASR_USED_MASK))
    else $error("enable readback wrong");

  // unused enable positions stay zero
  a_enable_unused: assert property (@(posedge clk) disable iff (reset) // [R7]
    (st.enable & ~ASR_USED_MASK) == 16'h0000)
    else $error("unused enable bit set");

  // no command leaves the register alone
  a_enable_hold: assert property (@(posedge clk) disable iff (reset) // [R7]
    !enable_write && !status_preset |=> st.enable == $past(st.enable))
    else $error("enable changed unasked");

  // a write lands on the next edge
  a_enable_write: assert property (@(posedge clk) disable iff (reset) // [R7]
    enable_write && !status_preset |=> st.enable == ($past(enable_wdata) & ASR_USED_MASK))
    else $error("enable write lost");

  // preset beats a write in the same cycle
  a_preset_wins: assert property (@(posedge clk) disable iff (reset) // [R9]
    status_preset && enable_write |=> st.enable == ASR_ENABLE_RST)
    else $error("write beat preset");

  // enable query returns the stored value
  a_enable_read: assert property (@(posedge clk) disable iff (reset) // [R7]
    query && query_sel == ASR_SEL_ENABLE |=> query_data == $past(st.enable))
    else $error("enable query wrong");

  // ----------------------------------------
  // event register
  // ----------------------------------------
  // a latched lower-limit bit survives without a clear
  a_event_hold: assert property (@(posedge clk) disable iff (reset) // [R10]
    st.event_reg[ASR_LOWER_BIT] && !clear_status && !(query && query_sel == ASR_SEL_EVENT)
    |=> st.event_reg[ASR_LOWER_BIT])
    else $error("event bit lost");

  // event query returns the value before clearing
  a_event_read: assert property (@(posedge clk) disable iff (reset) // [R10] [R6]
    chk_evq |=> query_data == $past(st.event_reg))
    else $error("event query wrong");

  // event query clears when nothing rises
  a_event_qclr: assert property (@(posedge clk) disable iff (reset) // [R10]
    chk_evq && chk_rise == 16'h0000 |=> st.event_reg == ASR_EVENT_RST)
    else $error("event query left bits");

  // clear-status clears when nothing rises
  a_event_cls: assert property (@(posedge clk) disable iff (reset) // [R10] [R2]
    clear_status && chk_rise == 16'h0000 |=> st.event_reg == ASR_EVENT_RST)
    else $error("clear-status left events");

  // a rise is latched even against a clear
  a_event_set_wins: assert property (@(posedge clk) disable iff (reset) // [R10]
    chk_rise != 16'h0000 |=> (st.event_reg & $past(chk_rise)) == $past(chk_rise))
    else $error("rising event lost");

  // without a clear no latched bit drops
  a_event_keep: assert property (@(posedge clk) disable iff (reset) // [R10]
    !clear_status && !chk_evq |=> (st.event_reg & $past(st.event_reg)) == $past(st.event_reg))
    else $error("event bits dropped");

  // bits appear only through a rise
  a_event_only_rise: assert property (@(posedge clk) disable iff (reset) // [R10]
    !reset |=> (st.event_reg & ~($past(st.event_reg) | $past(chk_rise))) == 16'h0000)
    else $error("event bit from nowhere");

  // unused event positions stay zero
  a_event_unused: assert property (@(posedge clk) disable iff (reset) // [R4]
    (st.event_reg & ~ASR_USED_MASK) == 16'h0000)
    else $error("unused event bit set");

  // ----------------------------------------
  // query handshake and summary
  // ----------------------------------------
  // every query gets one answer pulse
  a_valid_pulse: assert property (@(posedge clk) disable iff (reset) // [R6]
    query |=> query_valid)
    else $error("query not answered");

  // no answer without a query
  a_valid_idle: assert property (@(posedge clk) disable iff (reset) // [R6]
    !query |=> !query_valid)
    else $error("answer without query");

  // answer data held between queries
  a_data_hold: assert property (@(posedge clk) disable iff (reset) // [R6]
    !query |=> query_data == $past(query_data))
    else $error("answer data moved");

  // nothing enabled, nothing reported
  a_summary_gate: assert property (@(posedge clk) disable iff (reset) // [R8] [R11]
    st.enable == 16'h0000 && $past(st.enable) == 16'h0000 |-> !alarm_summary)
    else $error("summary without enable");

  // summary is the or of enabled events
  a_summary_form: assert property (@(posedge clk) disable iff (reset) // [R11] [R8]
    !reset |=> alarm_summary == $past(|(st.event_reg & st.enable)))
    else $error("summary mismatch");

endmodule

// ==== tb.sv ====
// tb: self-checking bench for asr_alarm_status
// assumes: asr_pkg compiled first; bench drives every port itself
`timescale 1ns/1ps
module tb;
  import asr_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        clk, reset, lower_limit, upper_limit;
  logic        queue_push, queue_pop, clear_status, status_preset;
  logic        enable_write, query, query_valid, alarm_summary;
  logic [3:0]  alarm_level;
  logic [15:0] enable_wdata, query_data, alarm_condition;
  asr_sel_t    query_sel;
  int          err_total, checked, cycles;

  asr_alarm_status dut (.clk(clk), .reset(reset), .alarm_level(alarm_level),
    .lower_limit(lower_limit), .upper_limit(upper_limit), .queue_push(queue_push),
    .queue_pop(queue_pop), .clear_status(clear_status), .status_preset(status_preset),
    .enable_write(enable_write), .enable_wdata(enable_wdata), .query(query),
    .query_sel(query_sel), .query_data(query_data), .query_valid(query_valid),
    .alarm_summary(alarm_summary), .alarm_condition(alarm_condition));

  // ----------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic go(int n);
    repeat (n) @(posedge clk);
  endtask

  // one query: strobe one cycle, answer settles after the next edge
  task automatic q(asr_sel_t sel, logic [15:0] exp);
    @(posedge clk) query <= 1'b1;
    query_sel <= sel;
    @(posedge clk) query <= 1'b0;
    #1;
    chk("query_valid", 16'h0001, {15'h0000, query_valid});
    chk("query_data", exp, query_data);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_alarms();
    @(posedge clk) alarm_level <= 4'b1010;
    lower_limit <= 1'b1;
    go(3);
    #1 chk("alarm_condition", 16'h1280, alarm_condition);
    q(ASR_SEL_COND, 16'h1280);
    q(ASR_SEL_COND, 16'h1280);
    chk("summary", 16'h0000, {15'h0000, alarm_summary});
  endtask

  task automatic t_enable();
    @(posedge clk) enable_write <= 1'b1;
    enable_wdata <= 16'hFFFF;
    @(posedge clk) enable_write <= 1'b0;
    q(ASR_SEL_ENABLE, 16'h33D0);
    go(2);
    #1 chk("summary", 16'h0001, {15'h0000, alarm_summary});
    q(ASR_SEL_EVENT, 16'h1280);
    q(ASR_SEL_EVENT, 16'h0000);
    go(2);
    #1 chk("summary", 16'h0000, {15'h0000, alarm_summary});
  endtask

  task automatic t_queue();
    @(posedge clk) queue_push <= 1'b1;
    upper_limit <= 1'b1;
    go(1);
    @(posedge clk) queue_push <= 1'b0;
    queue_pop <= 1'b1;
    @(posedge clk) queue_pop <= 1'b0;
    go(2);
    #1 chk("alarm_condition", 16'h3290, alarm_condition);
    @(posedge clk) clear_status <= 1'b1;
    @(posedge clk) clear_status <= 1'b0;
    go(2);
    #1 chk("alarm_condition", 16'h3280, alarm_condition);
  endtask

  task automatic t_preset();
    @(posedge clk) status_preset <= 1'b1;
    enable_write <= 1'b1;
    @(posedge clk) status_preset <= 1'b0;
    enable_write <= 1'b0;
    q(ASR_SEL_ENABLE, 16'h0000);
  endtask

  initial begin
    {reset, lower_limit, upper_limit, queue_push, queue_pop} = 5'b10000;
    {clear_status, status_preset, enable_write, query} = 4'b0000;
    alarm_level = 4'b0000;
    enable_wdata = 16'h0000;
    query_sel = ASR_SEL_COND;
    go(3);
    reset <= 1'b0;
    q(ASR_SEL_ENABLE, 16'h0000);
    t_alarms();
    t_enable();
    t_queue();
    t_preset();
    finish_test();
  end
endmodule
